// ---- common/epc_defines.svh ----
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH
`define EPC_PROG_CTRL_OFF 12'h01c
`define EPC_ARRAY_DATA_OFF 12'h020
`define EPC_ARRAY_ADDR_OFF 12'h024
`define EPC_BOOT_CTRL_OFF 12'h028
`define EPC_BOOT_STAT_OFF 12'h02c
`define EPC_PGM_BIT 0
`define EPC_LAT_BIT 2
`define EPC_PROG_CTRL_RST 8'h00
`define EPC_VFY_DONE_BIT 0
`define EPC_VFY_OK_BIT 1
`define EPC_START_BIT 0
`define EPC_PROGRAM_TIME_US 4000
`define EPC_CLK_MHZ 100
`define EPC_PROGRAM_TIME_CYC (`EPC_PROGRAM_TIME_US * `EPC_CLK_MHZ)
`endif

// ---- common/epc_pkg.sv ----
package epc_pkg;
  typedef enum logic [1:0] {
    EPC_MODE_NONE = 2'b00,
    EPC_MODE_PROG_VERIFY = 2'b01,
    EPC_MODE_VERIFY = 2'b10,
    EPC_MODE_DUMP = 2'b11
  } epc_mode_e;
  typedef struct packed {
    logic latch_mode_bit;
    logic program_power_bit;
  } epc_ctrl_s;
  typedef struct packed {
    logic we;
    logic [12:0] addr;
    logic [7:0] data;
  } epc_array_req_s;
endpackage : epc_pkg

// ---- rtl/epc_mode_decode.sv ----
`timescale 1ns/100ps
module epc_mode_decode
  import epc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins
  input wire logic mode_sel_high,
  input wire logic mode_sel_mid,
  input wire logic mode_sel_low,
  input wire logic sample,
  // result
  output epc_mode_e mode
);
  // pins are caught on a clocked sample, never under the reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= EPC_MODE_NONE;
    end else if (sample) begin
      case ({mode_sel_high, mode_sel_mid, mode_sel_low})
        3'b111: mode <= EPC_MODE_PROG_VERIFY;
        3'b110: mode <= EPC_MODE_VERIFY;
        3'b100: mode <= EPC_MODE_DUMP;
        default: mode <= EPC_MODE_NONE;
      endcase
    end
  end
endmodule : epc_mode_decode

// ---- rtl/epc_eprom_program_control.sv ----
// Functional notes
// - programming power follows the program-power bit one clock later (registered)
// - program-power can only be set while latch-mode already reads one
// - clearing latch-mode clears program-power in the same write
// - writing both bits set while latch is clear leaves latch set, power clear
// - latch-mode selects programming paths, otherwise normal array reads
// - first array write under latch-mode captures address and data
// - array reads return zero while latch-mode is set
// - both bits readable anytime; latch-mode writable anytime, program-power settable only under latch-mode; register resets to zero
// - control register holds only latch-mode and program-power bits
// - program-power sits at bit zero of the control register
// - three mode pins pick program/verify, verify only, or dump
// - programming indicator while latch-mode set in program/verify mode; verify indicator on success with source-select pin low in a verify mode
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`include "epc_defines.svh"
module epc_eprom_program_control
  import epc_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // array side
  output logic vpp_on,
  output logic array_prog_mode,
  output epc_array_req_s array_latch,
  input wire logic [7:0] array_rdata,
  // boot pins
  input wire logic mode_sel_high,
  input wire logic mode_sel_mid,
  input wire logic mode_sel_low,
  input wire logic source_sel_pin,
  output logic ext_addr_hi,
  output logic prog_led,
  output logic verify_led
);
  epc_ctrl_s ctrl_reg;
  epc_array_req_s latch_reg;
  logic [12:0] addr_reg;
  logic [7:0] rdata_reg;
  logic boot_start_reg;
  logic vfy_done_reg;
  logic vfy_ok_reg;
  logic prog_busy_reg;
  epc_mode_e mode;
  logic wr_en;
  logic rd_en;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // single-cycle access phase; no wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  epc_mode_decode u_mode (
    .pclk(pclk),
    .presetn(presetn),
    .mode_sel_high(mode_sel_high),
    .mode_sel_mid(mode_sel_mid),
    .mode_sel_low(mode_sel_low),
    .sample(boot_start_reg),
    .mode(mode)
  );

  // control register with interlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
    end else if (wr_en && hit(paddr, `EPC_PROG_CTRL_OFF)) begin
      ctrl_reg.latch_mode_bit <= pwdata[`EPC_LAT_BIT];
      // power only if latch was already set and stays set
      ctrl_reg.program_power_bit <= pwdata[`EPC_PGM_BIT] && ctrl_reg.latch_mode_bit
                                    && pwdata[`EPC_LAT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vpp_on <= 1'b0;
      array_prog_mode <= 1'b0;
    end else begin
      vpp_on <= ctrl_reg.program_power_bit;
      array_prog_mode <= ctrl_reg.latch_mode_bit;
    end
  end

  // array address pointer for the data window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 13'h0000;
    end else if (wr_en && hit(paddr, `EPC_ARRAY_ADDR_OFF)) begin
      addr_reg <= pwdata[12:0];
    end
  end

  // programming latch: first array write after latch is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= '0;
    end else if (!ctrl_reg.latch_mode_bit) begin
      latch_reg.we <= 1'b0;
    end else if (wr_en && hit(paddr, `EPC_ARRAY_DATA_OFF) && !latch_reg.we) begin
      latch_reg <= '{we: 1'b1, addr: addr_reg, data: pwdata[7:0]};
    end
  end
  assign array_latch = latch_reg;

  // boot control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_start_reg <= 1'b0;
    end else begin
      boot_start_reg <= wr_en && hit(paddr, `EPC_BOOT_CTRL_OFF) && pwdata[`EPC_START_BIT];
    end
  end

  // status written only by bootloader software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vfy_done_reg <= 1'b0;
      vfy_ok_reg <= 1'b0;
    end else if (wr_en && hit(paddr, `EPC_BOOT_STAT_OFF)) begin
      vfy_done_reg <= pwdata[`EPC_VFY_DONE_BIT];
      vfy_ok_reg <= pwdata[`EPC_VFY_OK_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_busy_reg <= 1'b0;
      prog_led <= 1'b0;
      verify_led <= 1'b0;
      ext_addr_hi <= 1'b0;
    end else begin
      prog_busy_reg <= ctrl_reg.latch_mode_bit && (mode == EPC_MODE_PROG_VERIFY);
      prog_led <= ctrl_reg.latch_mode_bit && (mode == EPC_MODE_PROG_VERIFY);
      // verify lamp only after a requested verify that passed
      verify_led <= vfy_done_reg && vfy_ok_reg && !source_sel_pin
                    && (mode == EPC_MODE_PROG_VERIFY || mode == EPC_MODE_VERIFY);
      ext_addr_hi <= addr_reg[12];
    end
  end

  // read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= ctrl_reg.latch_mode_bit ? 8'h00 : array_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `EPC_PROG_CTRL_OFF: begin
            prdata[`EPC_LAT_BIT] <= ctrl_reg.latch_mode_bit;
            prdata[`EPC_PGM_BIT] <= ctrl_reg.program_power_bit;
          end
          `EPC_ARRAY_DATA_OFF: prdata[7:0] <= ctrl_reg.latch_mode_bit ? 8'h00 : rdata_reg;
          `EPC_ARRAY_ADDR_OFF: prdata[12:0] <= addr_reg;
          `EPC_BOOT_CTRL_OFF: prdata[1:0] <= mode;
          `EPC_BOOT_STAT_OFF: prdata[1:0] <= {vfy_ok_reg, vfy_done_reg};
          default: pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        case (paddr)
          `EPC_PROG_CTRL_OFF, `EPC_ARRAY_DATA_OFF, `EPC_ARRAY_ADDR_OFF,
          `EPC_BOOT_CTRL_OFF, `EPC_BOOT_STAT_OFF: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  AST_PWR_NEEDS_LAT: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg.program_power_bit |-> ctrl_reg.latch_mode_bit) else $error("power without latch");
  AST_LAT_CLR_PWR: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ctrl_reg.latch_mode_bit) |-> !ctrl_reg.program_power_bit) else $error("power kept");
  AST_BOTH_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit(paddr, `EPC_PROG_CTRL_OFF) && !ctrl_reg.latch_mode_bit && pwdata[2] && pwdata[0])
    |=> ctrl_reg.latch_mode_bit && !ctrl_reg.program_power_bit) else $error("both set");
  AST_VPP: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 vpp_on == $past(ctrl_reg.program_power_bit)) else $error("vpp mismatch");
  AST_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 array_prog_mode == $past(ctrl_reg.latch_mode_bit)) else $error("mode mismatch");
  AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_reg.we && ctrl_reg.latch_mode_bit) |=> $stable(latch_reg.data) || !ctrl_reg.latch_mode_bit)
    else $error("latch overwritten");
  AST_RD_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_reg.latch_mode_bit && rd_en && paddr == `EPC_ARRAY_DATA_OFF) |-> prdata[7:0] == 8'h00)
    else $error("array read leaked");
  AST_UNUSED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `EPC_PROG_CTRL_OFF) |-> prdata[31:3] == '0 && !prdata[1])
    else $error("reserved bits");
  AST_LED: assert property (@(posedge pclk) disable iff (!presetn)
    verify_led |-> $past(vfy_ok_reg)) else $error("verify lamp");
endmodule : epc_eprom_program_control

// ---- verification/test_eprom_program_control.sv ----
`timescale 1ns/100ps
`include "epc_defines.svh"
module test_eprom_program_control;
  import epc_pkg::*;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, source_sel_pin = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, vpp_on, array_prog_mode, ext_addr_hi, prog_led, verify_led, err;
  logic [7:0] array_rdata = 8'ha5;
  logic [2:0] pins = 3'b000;
  epc_array_req_s array_latch;
  logic [2:0] mp [4] = '{3'b111, 3'b110, 3'b100, 3'b000};
  epc_mode_e me [4] = '{EPC_MODE_PROG_VERIFY, EPC_MODE_VERIFY, EPC_MODE_DUMP, EPC_MODE_NONE};
  int n_fail = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  epc_eprom_program_control epc_eprom_program_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vpp_on(vpp_on), .array_prog_mode(array_prog_mode), .array_latch(array_latch),
    .array_rdata(array_rdata), .mode_sel_high(pins[2]), .mode_sel_mid(pins[1]), .mode_sel_low(pins[0]),
    .source_sel_pin(source_sel_pin), .ext_addr_hi(ext_addr_hi), .prog_led(prog_led), .verify_led(verify_led));
  task automatic test_done();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // pready is sampled at the rising edge; request held until that edge, data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(negedge pclk);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task automatic boot(input logic [2:0] p);
    pins <= p;
    repeat (4) @(posedge pclk);
    wr(`EPC_BOOT_CTRL_OFF, 32'h1);
  endtask : boot
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    rdchk(`EPC_PROG_CTRL_OFF, 32'h0);
    `CHK(vpp_on, 1'b0)
    wr(`EPC_PROG_CTRL_OFF, 32'h1);
    rdchk(`EPC_PROG_CTRL_OFF, 32'h0);
    wr(`EPC_PROG_CTRL_OFF, 32'h5);
    rdchk(`EPC_PROG_CTRL_OFF, 32'h4);
    `CHK(vpp_on, 1'b0)
    `CHK(array_prog_mode, 1'b1)
    wr(`EPC_ARRAY_ADDR_OFF, 32'h1700);
    wr(`EPC_ARRAY_DATA_OFF, 32'h55);
    `CHK(array_latch, {1'b1, 13'h1700, 8'h55})
    `CHK(ext_addr_hi, 1'b1)
    rdchk(`EPC_ARRAY_DATA_OFF, 32'h0);
    wr(`EPC_PROG_CTRL_OFF, 32'hff);
    rdchk(`EPC_PROG_CTRL_OFF, 32'h5);
    `CHK(vpp_on, 1'b1)
    wr(`EPC_PROG_CTRL_OFF, 32'h1);
    rdchk(`EPC_PROG_CTRL_OFF, 32'h0);
    `CHK(vpp_on, 1'b0)
    `CHK(array_prog_mode, 1'b0)
    rdchk(`EPC_ARRAY_DATA_OFF, 32'ha5);
    wr(`EPC_ARRAY_ADDR_OFF, 32'h1ff0);
    `CHK(ext_addr_hi, 1'b1)
    wr(`EPC_ARRAY_ADDR_OFF, 32'h0020);
    `CHK(ext_addr_hi, 1'b0)
    wr(`EPC_ARRAY_ADDR_OFF, 32'h1eff);
    rdchk(`EPC_ARRAY_ADDR_OFF, 32'h1eff);
    apb(1'b0, 12'h3fc, 32'h0);
    `CHK(err, 1'b1)
    for (int i = 0; i < 4; i++) begin
      boot(mp[i]);
      rdchk(`EPC_BOOT_CTRL_OFF, {30'h0, me[i]});
    end
    boot(3'b111);
    wr(`EPC_PROG_CTRL_OFF, 32'h4);
    `CHK(prog_led, 1'b1)
    wr(`EPC_PROG_CTRL_OFF, 32'h0);
    source_sel_pin <= 0;
    boot(3'b110);
    wr(`EPC_BOOT_STAT_OFF, 32'h1);
    `CHK(verify_led, 1'b0)
    wr(`EPC_BOOT_STAT_OFF, 32'h3);
    `CHK(verify_led, 1'b1)
    test_done();
  end
endmodule : test_eprom_program_control
